// [pkg/cfr_pkg.sv]
// Package for the CAN acceptance filter routing control block.
// Assumes a 32-bit classic Wishbone slave; offsets are byte addresses.
`default_nettype none

package cfr_pkg;

   // Filter range held by this block
   localparam int FIRST_FILTER = 4;
   localparam int NUM_GROUPS = 3;
   localparam int FILTERS_PER_GROUP = 4;
   localparam int NUM_FILTERS = NUM_GROUPS * FILTERS_PER_GROUP;

   // Register offsets (byte addresses) and group indices
   localparam logic [7:0] FILTER_CTRL_GROUP_1_OFFSET = 8'h04;
   localparam logic [7:0] FILTER_CTRL_GROUP_2_OFFSET = 8'h08;
   localparam logic [7:0] FILTER_CTRL_GROUP_3_OFFSET = 8'h0C;
   localparam logic [7:0] MATCH_PROBE_OFFSET = 8'h10;
   localparam logic [7:0] MATCH_RESULT_OFFSET = 8'h14;
   localparam int FIRST_GROUP = 1;

   // Field layout inside one filter byte
   localparam int FILTER_ON_BIT = 7;
   localparam int MASK_PICK_LSB = 5;
   localparam int MASK_PICK_W = 2;
   localparam int FIFO_TARGET_LSB = 0;
   localparam int FIFO_TARGET_W = 5;

   // Reset values
   localparam logic [31:0] FILTER_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] MATCH_PROBE_RESET = 32'h0000_0000;

   // Acceptance identifier width (29-bit extended identifier)
   localparam int ID_W = 29;

endpackage

`default_nettype wire

// [hdl/cfr_filter_routing.sv]
// Filter control registers for acceptance filters 4..15, with a match helper.
// Assumes a classic Wishbone master on clk_i and the mask and filter
// identifier values supplied by the surrounding comparator logic.
`default_nettype none

// Behaviour
// - Per-filter enable bit gates participation
// - Two-bit selector picks acceptance mask 0..3
// - Five-bit selector names target FIFO 0..31
// - Byte layout: enable, mask pick, FIFO target
// - Four filters per register, lowest in byte 0
// - All fields read/write, clear to zero at reset
// - Mask bit 1 compares, 0 is don't-care
module cfr_filter_routing #(
   parameter int NUM_FILTERS = cfr_pkg::NUM_FILTERS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   // Per-filter configuration toward the comparator and FIFO writer
   output logic [NUM_FILTERS-1:0] filter_on_o,
   output logic [2*NUM_FILTERS-1:0] filter_mask_pick_o,
   output logic [5*NUM_FILTERS-1:0] filter_fifo_target_o,
   // Acceptance masks and per-filter identifiers from the comparator side
   input wire logic [4*cfr_pkg::ID_W-1:0] accept_mask_i,
   input wire logic [NUM_FILTERS*cfr_pkg::ID_W-1:0] filter_id_i,
   input wire logic [cfr_pkg::ID_W-1:0] frame_id_i,
   // Per-filter match result for the current frame identifier
   output logic [NUM_FILTERS-1:0] filter_match_o
);

   // Number of 32-bit control words; each word carries four filter bytes
   // Filter counts that are not a multiple of four are not supported: the
   // spare bytes of a partial word would have no home in this map
   localparam int NGRP = NUM_FILTERS / cfr_pkg::FILTERS_PER_GROUP;

   // Control registers, one word per group of four filters
   logic [31:0] ctrl_reg [NGRP];
   logic [31:0] ctrl_next [NGRP];
   // Software probe identifier, lets software test the filters directly
   logic [cfr_pkg::ID_W-1:0] probe_reg;
   logic [cfr_pkg::ID_W-1:0] probe_next;
   // Bus answer state
   logic ack_reg;
   logic ack_next;
   logic err_reg;
   logic err_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   // Match vectors for frame and for probe
   logic [NUM_FILTERS-1:0] frame_hit;
   logic [NUM_FILTERS-1:0] probe_hit;

   // Byte-lane merge for a Wishbone write
   // Each byte lane is one filter, so software may retarget a single filter
   // with one narrow write and leave its three neighbours untouched
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Word index of a control register, or -1 when not a control register
   // The control words sit at consecutive word addresses after the first,
   // so one compare per word is cheaper than a full address decoder
   function automatic int group_of(input logic [7:0] adr);
      int g;
      g = -1;
      for (int i = 0; i < NGRP; i++) begin
         if (adr == 8'(cfr_pkg::FILTER_CTRL_GROUP_1_OFFSET + 8'(4 * i))) begin
            g = i;
         end
      end
      return g;
   endfunction

   // Compare one filter against an identifier under its selected mask
   // Shared by the frame path and the software probe path, so both see
   // exactly the same acceptance decision
   // The mask is chosen per filter, so several filters may share one mask
   function automatic logic filter_hits(input int f,
                                        input logic [cfr_pkg::ID_W-1:0] id,
                                        input logic [31:0] word);
      logic [7:0] fb;
      logic [1:0] pick;
      logic [cfr_pkg::ID_W-1:0] mask;
      logic [cfr_pkg::ID_W-1:0] ref_id;
      fb = word[8*(f % cfr_pkg::FILTERS_PER_GROUP) +: 8];
      pick = fb[cfr_pkg::MASK_PICK_LSB +: cfr_pkg::MASK_PICK_W];
      mask = accept_mask_i[int'(pick)*cfr_pkg::ID_W +: cfr_pkg::ID_W];
      ref_id = filter_id_i[f*cfr_pkg::ID_W +: cfr_pkg::ID_W];
      // A cleared mask bit removes that identifier bit from the compare
      return fb[cfr_pkg::FILTER_ON_BIT]
         && (((id ^ ref_id) & mask) == '0);
   endfunction

   // Break the registers out into per-filter fields
   // Fields come straight from flip-flops, so the comparator and the FIFO
   // writer see a glitch-free configuration
   // The match vectors are combinational: a new frame identifier is judged
   // in the same cycle, at the cost of a deep compare path
   always_comb begin
      for (int f = 0; f < NUM_FILTERS; f++) begin
         logic [7:0] fb;
         fb = ctrl_reg[f / 4][8*(f % 4) +: 8];
         filter_on_o[f] = fb[cfr_pkg::FILTER_ON_BIT];
         filter_mask_pick_o[2*f +: 2] = fb[cfr_pkg::MASK_PICK_LSB +: 2];
         filter_fifo_target_o[5*f +: 5] = fb[cfr_pkg::FIFO_TARGET_LSB +: 5];
         frame_hit[f] = filter_hits(f, frame_id_i, ctrl_reg[f / 4]);
         probe_hit[f] = filter_hits(f, probe_reg, ctrl_reg[f / 4]);
      end
   end

   // Only the frame result leaves the block; the probe result is read
   // back over the bus
   assign filter_match_o = frame_hit;

   // Next state of registers and bus answer
   // Every access is answered one cycle after it is taken
   // A strobe held high during the answer cycle is not taken again, so a
   // master that is slow to drop its strobe cannot write twice
   // Read data is captured once and then held, so it stays stable for a
   // master that samples late in the answer cycle
   always_comb begin
      int g;
      logic req;
      g = group_of(adr_i);
      // One access per request: the cycle after ack the strobe must drop
      req = cyc_i && stb_i && !ack_reg && !err_reg;
      for (int i = 0; i < NGRP; i++) begin
         ctrl_next[i] = ctrl_reg[i];
      end
      probe_next = probe_reg;
      ack_next = 1'b0;
      err_next = 1'b0;
      rdata_next = rdata_reg;
      if (req) begin
         if (g >= 0) begin
            // Filter control word: full read/write
            ack_next = 1'b1;
            if (we_i) begin
               ctrl_next[g] = lane_merge(ctrl_reg[g], dat_i, sel_i);
            end else begin
               rdata_next = ctrl_reg[g];
            end
         end else if (adr_i == cfr_pkg::MATCH_PROBE_OFFSET) begin
            ack_next = 1'b1;
            if (we_i) begin
               probe_next = cfr_pkg::ID_W'(lane_merge(32'(probe_reg), dat_i, sel_i));
            end else begin
               rdata_next = 32'(probe_reg);
            end
         end else if (adr_i == cfr_pkg::MATCH_RESULT_OFFSET) begin
            // Read-only; writes are acknowledged and dropped
            ack_next = 1'b1;
            rdata_next = we_i ? rdata_reg : 32'(probe_hit);
         end else begin
            // Unmapped address answers with an error
            // Only the read data clears here, so a stray access cannot alter routing
            err_next = 1'b1;
            rdata_next = 32'h0000_0000;
         end
      end
   end

   // Register everything; synchronous reset clears all fields
   // After reset every filter is disabled, picks mask 0 and targets FIFO 0,
   // so no frame is routed until software enables a filter
   // Reset is synchronous, so rst_i must be held across a clock edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NGRP; i++) begin
            ctrl_reg[i] <= cfr_pkg::FILTER_CTRL_RESET;
         end
         probe_reg <= cfr_pkg::ID_W'(cfr_pkg::MATCH_PROBE_RESET);
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < NGRP; i++) begin
            ctrl_reg[i] <= ctrl_next[i];
         end
         probe_reg <= probe_next;
         ack_reg <= ack_next;
         err_reg <= err_next;
         rdata_reg <= rdata_next;
      end
   end

   // Bus outputs are plain register copies
   // Acknowledge and error are one-cycle pulses and never rise together
   assign ack_o = ack_reg;
   assign err_o = err_reg;
   assign dat_o = rdata_reg;

endmodule

`default_nettype wire

// [sim/cfr_filter_routing_props.sv]
// Checker for the filter routing control block.
// Sees only the top module's ports; bound to every instance below.
`default_nettype none
module cfr_props #(parameter int NUM_FILTERS = 12) (
   input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i, dat_o,
   input wire logic [NUM_FILTERS-1:0] filter_on_o, filter_match_o,
   input wire logic [2*NUM_FILTERS-1:0] filter_mask_pick_o,
   input wire logic [5*NUM_FILTERS-1:0] filter_fifo_target_o,
   input wire logic [4*cfr_pkg::ID_W-1:0] accept_mask_i,
   input wire logic [NUM_FILTERS*cfr_pkg::ID_W-1:0] filter_id_i,
   input wire logic [cfr_pkg::ID_W-1:0] frame_id_i);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A request the slave takes: strobe up with no answer pending
   sequence s_take; cyc_i && stb_i && !ack_o && !err_o; endsequence
   // A taken write to register a with byte lane l enabled
   sequence s_wr(a, l); s_take ##0 (we_i && adr_i == a && sel_i[l]); endsequence
   a_answer_next: assert property (s_take |=> ack_o != err_o) else $error("no answer");
   a_answer_pulse: assert property ((ack_o || err_o) |=> !ack_o && !err_o) else $error("long");
   a_err_unmapped: assert property ((s_take ##0 adr_i > 8'h14) |=> err_o) else $error("no err");
   a_reset_zero: assert property ($fell(rst_i) |-> filter_on_o == '0 && filter_mask_pick_o == '0
      && filter_fifo_target_o == '0) else $error("reset value");
   a_low_byte: assert property (s_wr(8'h04, 0) |=> filter_on_o[0] == $past(dat_i[7])
      && filter_mask_pick_o[1:0] == $past(dat_i[6:5])
      && filter_fifo_target_o[4:0] == $past(dat_i[4:0])) else $error("low byte");
   a_top_byte: assert property (s_wr(8'h0C, 3) |=> filter_on_o[11] == $past(dat_i[31])
      && filter_fifo_target_o[59:55] == $past(dat_i[28:24])) else $error("top byte");
   // Without a taken write the enable and FIFO target fields must not move
   a_cfg_hold: assert property (!(cyc_i && stb_i && !ack_o && !err_o && we_i)
      |=> $stable(filter_on_o) && $stable(filter_fifo_target_o)) else $error("moved");
   a_off_no_match: assert property ((filter_match_o & ~filter_on_o) == '0) else $error("off");
   a_match_one: assert property (filter_match_o[0] == (filter_on_o[0] &&
      ((frame_id_i ^ filter_id_i[28:0]) & accept_mask_i[29*filter_mask_pick_o[1:0]+:29]) == '0))
      else $error("match");
endmodule
bind cfr_filter_routing cfr_props #(.NUM_FILTERS(NUM_FILTERS)) i_props (.*);
`default_nettype wire

// [sim/test_cfr_filter_routing.sv]
// Self-checking bench for the filter routing control block.
// Drives the Wishbone port and the comparator inputs directly.
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_mismatch++; \
 $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module test_cfr_filter_routing;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, err_o;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic [11:0] filter_on_o, filter_match_o;
   logic [23:0] filter_mask_pick_o;
   logic [59:0] filter_fifo_target_o;
   logic [115:0] accept_mask_i = '0;
   logic [347:0] filter_id_i = '0;
   logic [28:0] frame_id_i = '0;
   logic [31:0] sh [3] = '{default: 32'h0}; // Shadow of the control registers
   logic [33:0] q [$]; // Notes: expected err, read flag, read data
   logic [33:0] nt;
   logic [31:0] xr = 32'h0; // Expected read data outside the control words
   int n_mismatch = 0, n_checks = 0, seed = 28;
   always #4 clk_i = ~clk_i;
   cfr_filter_routing i_dut (.*);
   // Counts and verdict
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One classic cycle; the shadow follows enabled lanes of a write
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
         input logic [31:0] d, input logic e);
      int n;
      n = 0;
      q.push_back({e, !w && !e, (a < 8'h10) ? sh[a[3:2]-2'd1] : xr});
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; sel_i <= s; dat_i <= d;
      do begin @(posedge clk_i); n++; end while (!ack_o && !err_o && n < 20);
      if (n == 20) begin n_mismatch++; end_sim(); end
      if (w && a < 8'h10) for (int b = 0; b < 4; b++) if (s[b]) sh[a[3:2]-2'd1][8*b+:8] = d[8*b+:8];
      cyc_i <= 0; stb_i <= 0;
      @(posedge clk_i);
   endtask
   // Each answer takes the oldest note
   always @(posedge clk_i) if (ack_o || err_o) begin
      nt = q.pop_front();
      `CHK("err", nt[33], err_o)
      if (nt[32]) `CHK("rdata", nt[31:0], dat_o)
   end
   // Expected match of filter f for identifier id, from the shadow fields
   function automatic logic hit(input int f, input logic [28:0] id);
      logic [7:0] v;
      v = sh[f/4][8*(f%4)+:8];
      return v[7] && ((id ^ filter_id_i[29*f+:29]) & accept_mask_i[29*v[6:5]+:29]) == '0;
   endfunction
   // Per-filter outputs against the shadow; match worked out from fields
   task automatic chk_out;
      logic [7:0] v;
      logic m;
      for (int f = 0; f < 12; f++) begin
         v = sh[f/4][8*(f%4)+:8];
         m = hit(f, frame_id_i);
         `CHK("on", v[7], filter_on_o[f])
         `CHK("mask", v[6:5], filter_mask_pick_o[2*f+:2])
         `CHK("fifo", v[4:0], filter_fifo_target_o[5*f+:5])
         `CHK("match", m, filter_match_o[f])
      end
   endtask
   initial begin
      logic [7:0] a;
      logic [28:0] fid;
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      for (int t = 0; t < 40; t++) begin
         a = 8'h04 + 8'(4 * (t % 3));
         // First pass reads reset values; later ones write random lanes
         if (t >= 3) bus(1, a, 4'($random(seed)), $random(seed), 0);
         bus(0, a, 4'hF, 32'h0, 0);
         fid = 29'($random(seed));
         frame_id_i <= fid;
         accept_mask_i <= 116'({$random(seed), $random(seed), $random(seed), $random(seed)});
         // Even filters hold the exact identifier, odd ones a random one
         for (int f = 0; f < 12; f++) filter_id_i[29*f+:29] <= f[0] ? 29'($random(seed)) : fid;
         @(posedge clk_i);
         chk_out();
         $display("test %0d done", t);
      end
      // Probe word keeps 29 bits; its match vector ignores writes
      xr = {3'b000, fid};
      bus(1, 8'h10, 4'hF, {3'b111, fid}, 0);
      bus(0, 8'h10, 4'hF, 32'h0, 0);
      for (int f = 0; f < 12; f++) xr[f] = hit(f, fid);
      xr[31:12] = '0;
      bus(0, 8'h14, 4'hF, 32'h0, 0);
      bus(1, 8'h14, 4'hF, 32'hFFFF_FFFF, 0);
      bus(0, 8'h14, 4'hF, 32'h0, 0);
      $display("test probe done");
      bus(0, 8'h20, 4'hF, 32'h0, 1); // Unmapped place is refused
      end_sim();
   end
endmodule
`default_nettype wire
